// file: design/ccsf_pkg.sv
`default_nettype none
package ccsf_pkg;

    // direct sfr addresses of the core registers
    localparam logic [7:0] CCSF_ADDR_STACK_POINTER       = 8'h81;
    localparam logic [7:0] CCSF_ADDR_DATA_POINTER_LOW    = 8'h82;
    localparam logic [7:0] CCSF_ADDR_DATA_POINTER_HIGH   = 8'h83;
    localparam logic [7:0] CCSF_ADDR_PROGRAM_STATUS_WORD = 8'hD0;
    localparam logic [7:0] CCSF_ADDR_ACCUMULATOR         = 8'hE0;
    localparam logic [7:0] CCSF_ADDR_SECOND_OPERAND      = 8'hF0;
    localparam logic [7:0] CCSF_ADDR_AUXILIARY_CONTROL   = 8'hF8;

    // values after reset
    localparam logic [7:0]  CCSF_RST_STACK_POINTER = 8'h07;
    localparam logic [7:0]  CCSF_RST_BYTE          = 8'h00;
    localparam logic [15:0] CCSF_RST_DATA_POINTER  = 16'h0000;
    localparam logic [3:0]  CCSF_RST_AUX           = 4'h0;
    localparam logic [1:0]  CCSF_RST_BANK          = 2'h0;

    // field positions in the status word
    localparam int CCSF_PSW_ARITH_CARRY   = 7;
    localparam int CCSF_PSW_HALF_CARRY    = 6;
    localparam int CCSF_PSW_USER_FLAG_A   = 5;
    localparam int CCSF_PSW_BANK_HI       = 4;
    localparam int CCSF_PSW_BANK_LO       = 3;
    localparam int CCSF_PSW_OVERFLOW      = 2;
    localparam int CCSF_PSW_USER_FLAG_B   = 1;
    localparam int CCSF_PSW_PARITY        = 0;
    // auxiliary control: bits 3..0 implemented, bit 0 selects the pointer
    localparam int CCSF_AUX_POINTER_SELECT = 0;
    localparam int CCSF_AUX_WIDTH          = 4;

    // stack pointer steps: one byte for push/pop, two for a return address
    localparam logic [7:0] CCSF_STACK_STEP_BYTE = 8'h01;
    localparam logic [7:0] CCSF_STACK_STEP_CALL = 8'h02;

    typedef enum logic [3:0] {
        ALU_NONE, ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_MUL, ALU_DIV,
        ALU_SETC, ALU_CLRC, ALU_CARRY_LOAD
    } ccsf_alu_op_type;

    typedef enum logic [2:0] {
        STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET
    } ccsf_stack_op_type;

    typedef enum logic [1:0] {
        DP_NONE, DP_LOAD, DP_INC
    } ccsf_dp_op_type;

    // one arithmetic request from the instruction decoder
    typedef struct packed {
        ccsf_alu_op_type op;
        logic [7:0]      operand;
        logic            carry_val;
    } ccsf_alu_req_type;

    // one byte write from the core datapath
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } ccsf_byte_wr_type;

    // arithmetic outcome with per-field update enables
    typedef struct packed {
        logic       upd_acc;
        logic [7:0] acc;
        logic       upd_b;
        logic [7:0] b;
        logic       upd_cy;
        logic       cy;
        logic       upd_ac;
        logic       ac;
        logic       upd_ov;
        logic       ov;
    } ccsf_alu_res_type;

endpackage : ccsf_pkg
`default_nettype wire

// file: design/ccsf_alu_flags.sv
`timescale 1ns/1ps
`default_nettype none
module ccsf_alu_flags
    import ccsf_pkg::*;
(
    input  wire logic [7:0]       acc,    // current accumulator
    input  wire logic [7:0]       b_reg,  // current second operand
    input  wire logic             cy_in,  // current carry
    input  wire ccsf_alu_req_type req,    // request from decoder
    output ccsf_alu_res_type      res     // results and enables
);

    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [15:0] prod;
    logic        cin;

    // carry-in only for addc and subb
    assign cin = (req.op == ALU_ADDC || req.op == ALU_SUBB) ? cy_in : 1'b0;

    always_comb begin
        res  = '0;
        sum9 = 9'h000;
        nib5 = 5'h00;
        prod = {8'h00, acc} * {8'h00, b_reg};
        unique case (req.op)
            ALU_ADD, ALU_ADDC: begin
                sum9 = {1'b0, acc} + {1'b0, req.operand} + {8'h00, cin};
                nib5 = {1'b0, acc[3:0]} + {1'b0, req.operand[3:0]} + {4'h0, cin};
                res.upd_acc = 1'b1;
                res.acc     = sum9[7:0];
                res.upd_cy  = 1'b1;
                res.cy      = sum9[8];
                res.upd_ac  = 1'b1;
                res.ac      = nib5[4];
                res.upd_ov  = 1'b1;
                res.ov      = (acc[7] == req.operand[7]) && (sum9[7] != acc[7]);
            end
            ALU_SUBB: begin
                // borrow appears as bit 8 of the two's complement difference
                sum9 = {1'b0, acc} - {1'b0, req.operand} - {8'h00, cin};
                nib5 = {1'b0, acc[3:0]} - {1'b0, req.operand[3:0]} - {4'h0, cin};
                res.upd_acc = 1'b1;
                res.acc     = sum9[7:0];
                res.upd_cy  = 1'b1;
                res.cy      = sum9[8];
                res.upd_ac  = 1'b1;
                res.ac      = nib5[4];
                res.upd_ov  = 1'b1;
                res.ov      = (acc[7] != req.operand[7]) && (sum9[7] != acc[7]);
            end
            ALU_MUL: begin
                res.upd_acc = 1'b1;
                res.acc     = prod[7:0];
                res.upd_b   = 1'b1;
                res.b       = prod[15:8];
                res.upd_cy  = 1'b1;
                res.upd_ov  = 1'b1;
                res.ov      = (prod[15:8] != 8'h00);
            end
            ALU_DIV: begin
                // divide by zero flags overflow and keeps both operands
                res.upd_cy  = 1'b1;
                res.upd_ov  = 1'b1;
                res.ov      = (b_reg == 8'h00);
                if (b_reg != 8'h00) begin
                    res.upd_acc = 1'b1;
                    res.acc     = acc / b_reg;
                    res.upd_b   = 1'b1;
                    res.b       = acc % b_reg;
                end
            end
            ALU_SETC: begin
                res.upd_cy = 1'b1;
                res.cy     = 1'b1;
            end
            ALU_CLRC: begin
                res.upd_cy = 1'b1;
            end
            ALU_CARRY_LOAD: begin
                res.upd_cy = 1'b1;
                res.cy     = req.carry_val;
            end
            ALU_NONE: begin
                res = '0;
            end
            default: begin
                res = '0;
            end
        endcase
    end

endmodule : ccsf_alu_flags
`default_nettype wire

// file: design/ccsf_data_pointer_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ccsf_data_pointer_bank
    import ccsf_pkg::*;
(
    input  wire logic        clk,         // system clock
    input  wire logic        rst_n,       // synchronised reset
    input  wire logic        sel,         // active pointer select
    input  wire logic        wr_low,      // sfr write low byte
    input  wire logic        wr_high,     // sfr write high byte
    input  wire logic [7:0]  wdata,       // sfr write data
    input  wire ccsf_dp_op_type dp_op,    // core load or increment
    input  wire logic [15:0] load_value,  // core load value
    output logic [15:0]      ptr_q [2],   // both pointers
    output logic [15:0]      ptr_d [2]    // both next values
);

    // one pointer per entry; only the selected one sees any access
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        logic hit;
        assign hit = (sel == 1'(i));

        always_comb begin
            ptr_d[i] = ptr_q[i];
            if (hit) begin
                // core operations win over a same-cycle sfr write
                unique case (dp_op)
                    DP_LOAD: ptr_d[i] = load_value;
                    DP_INC:  ptr_d[i] = ptr_q[i] + 16'h0001;
                    DP_NONE: begin
                        if (wr_low) begin
                            ptr_d[i][7:0] = wdata;
                        end
                        if (wr_high) begin
                            ptr_d[i][15:8] = wdata;
                        end
                    end
                    default: ptr_d[i] = ptr_q[i];
                endcase
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ptr_q[i] <= CCSF_RST_DATA_POINTER;
            end else begin
                ptr_q[i] <= ptr_d[i];
            end
        end
    end

endmodule : ccsf_data_pointer_bank
`default_nettype wire

// file: design/ccsf_core_sfr.sv
// Overview of operation
// - accumulator is 8-bit read/write, feeds and receives arithmetic results
// - second operand register feeds mul/div with accumulator, else scratch
// - stack pointer steps by two on call and back on return
// - push increments stack pointer, pop decrements it
// - two data pointers share addresses; select bit picks the one accessed
// - each data pointer is 16 bits from high and low bytes
// - add, addc and subb update carry, overflow and half carry
// - mul and div clear carry, set overflow on a product over 255 or a divide by zero, keep half carry
// - set/clear carry force it; bit ops load carry from result only
// - two bank select bits choose register bank 0 to 3
// - parity flag follows accumulator one-bit count every cycle
// - two user flags in status word only store what software writes
// - carry bit 7, half carry bit 6, overflow bit 2, all software r/w
`timescale 1ns/1ps
`default_nettype none
module ccsf_core_sfr
    import ccsf_pkg::*;
(
    input  wire logic        CLK_SYS,        // system clock, 20 MHz
    input  wire logic        ARST_N,         // async reset, active low
    input  wire logic [7:0]  SFR_ADDR,       // direct sfr address
    input  wire logic        SFR_WR,         // sfr write strobe
    input  wire logic [7:0]  SFR_WDATA,      // sfr write data
    input  wire logic        SFR_RD,         // sfr read strobe
    input  wire ccsf_alu_req_type ALU_REQ,   // arithmetic / carry request
    input  wire ccsf_byte_wr_type ACC_WR,    // core accumulator write
    input  wire ccsf_stack_op_type STACK_OP, // stack pointer operation
    input  wire ccsf_dp_op_type DP_OP,       // data pointer operation
    input  wire logic [15:0] DP_LOAD_VALUE,  // data pointer load value
    output logic [7:0]       SFR_RDATA,      // read data, next cycle
    output logic             SFR_HIT,        // read hit a mapped sfr
    output logic [7:0]       ACC_VALUE,      // accumulator
    output logic [7:0]       B_VALUE,        // second operand
    output logic [7:0]       STACK_POINTER,  // stack top address
    output logic [15:0]      DATA_POINTER,   // active data pointer
    output logic [7:0]       PSW_VALUE,      // program status word
    output logic [7:0]       REG_BANK_BASE,  // base of working registers
    output logic [2:0]       AUX_CTRL        // other auxiliary control bits
);

    // reset release through two flops
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // register state
    logic [7:0]                acc_q;
    logic [7:0]                acc_d;
    logic [7:0]                b_q;
    logic [7:0]                b_d;
    logic [7:0]                sp_q;
    logic [7:0]                sp_d;
    logic                      cy_q;
    logic                      cy_d;
    logic                      ac_q;
    logic                      ac_d;
    logic                      ov_q;
    logic                      ov_d;
    logic                      user_flag_a_q;
    logic                      user_flag_b_q;
    logic [1:0]                bank_select_q;
    logic                      parity_q;
    logic [CCSF_AUX_WIDTH-1:0] aux_q;
    logic [CCSF_AUX_WIDTH-1:0] aux_d;
    logic [15:0]               data_pointer_out_q;
    logic [7:0]                rdata_q;
    logic                      hit_q;

    // address decode of the write strobe
    logic wr_sp;
    logic wr_dpl;
    logic wr_dph;
    logic wr_psw;
    logic wr_acc;
    logic wr_b;
    logic wr_aux;

    assign wr_sp  = SFR_WR && (SFR_ADDR == CCSF_ADDR_STACK_POINTER);
    assign wr_dpl = SFR_WR && (SFR_ADDR == CCSF_ADDR_DATA_POINTER_LOW);
    assign wr_dph = SFR_WR && (SFR_ADDR == CCSF_ADDR_DATA_POINTER_HIGH);
    assign wr_psw = SFR_WR && (SFR_ADDR == CCSF_ADDR_PROGRAM_STATUS_WORD);
    assign wr_acc = SFR_WR && (SFR_ADDR == CCSF_ADDR_ACCUMULATOR);
    assign wr_b   = SFR_WR && (SFR_ADDR == CCSF_ADDR_SECOND_OPERAND);
    assign wr_aux = SFR_WR && (SFR_ADDR == CCSF_ADDR_AUXILIARY_CONTROL);

    // arithmetic unit, purely combinational
    ccsf_alu_res_type alu_res;

    ccsf_alu_flags u_alu (
        .acc   (acc_q),
        .b_reg (b_q),
        .cy_in (cy_q),
        .req   (ALU_REQ),
        .res   (alu_res)
    );

    // both physical data pointers
    logic [15:0] ptr_q [2];
    logic [15:0] ptr_d [2];

    ccsf_data_pointer_bank u_data_pointer (
        .clk        (CLK_SYS),
        .rst_n      (rst_n_q),
        .sel        (aux_q[CCSF_AUX_POINTER_SELECT]),
        .wr_low     (wr_dpl),
        .wr_high    (wr_dph),
        .wdata      (SFR_WDATA),
        .dp_op      (DP_OP),
        .load_value (DP_LOAD_VALUE),
        .ptr_q      (ptr_q),
        .ptr_d      (ptr_d)
    );

    // accumulator next value: alu, then core write, then sfr write.
    // hardware wins so a result is never lost to a stray sfr write
    always_comb begin
        acc_d = acc_q;
        if (alu_res.upd_acc) begin
            acc_d = alu_res.acc;
        end else if (ACC_WR.we) begin
            acc_d = ACC_WR.data;
        end else if (wr_acc) begin
            acc_d = SFR_WDATA;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_q <= CCSF_RST_BYTE;
        end else begin
            acc_q <= acc_d;
        end
    end

    // second operand: mul/div results first, else a plain sfr write
    always_comb begin
        b_d = b_q;
        if (alu_res.upd_b) begin
            b_d = alu_res.b;
        end else if (wr_b) begin
            b_d = SFR_WDATA;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            b_q <= CCSF_RST_BYTE;
        end else begin
            b_q <= b_d;
        end
    end

    // stack pointer: wraps modulo 256, as in any 8-bit stack
    always_comb begin
        sp_d = sp_q;
        unique case (STACK_OP)
            STK_PUSH: sp_d = sp_q + CCSF_STACK_STEP_BYTE;
            STK_POP:  sp_d = sp_q - CCSF_STACK_STEP_BYTE;
            STK_CALL: sp_d = sp_q + CCSF_STACK_STEP_CALL;
            STK_RET:  sp_d = sp_q - CCSF_STACK_STEP_CALL;
            STK_NONE: begin
                if (wr_sp) begin
                    sp_d = SFR_WDATA;
                end
            end
            default:  sp_d = sp_q;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sp_q <= CCSF_RST_STACK_POINTER;
        end else begin
            sp_q <= sp_d;
        end
    end

    // arithmetic flags; an alu update beats a same-cycle sfr write
    always_comb begin
        cy_d = cy_q;
        ac_d = ac_q;
        ov_d = ov_q;
        if (wr_psw) begin
            cy_d = SFR_WDATA[CCSF_PSW_ARITH_CARRY];
            ac_d = SFR_WDATA[CCSF_PSW_HALF_CARRY];
            ov_d = SFR_WDATA[CCSF_PSW_OVERFLOW];
        end
        if (alu_res.upd_cy) begin
            cy_d = alu_res.cy;
        end
        if (alu_res.upd_ac) begin
            ac_d = alu_res.ac;
        end
        if (alu_res.upd_ov) begin
            ov_d = alu_res.ov;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cy_q <= 1'b0;
            ac_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            cy_q <= cy_d;
            ac_q <= ac_d;
            ov_q <= ov_d;
        end
    end

    // user flags and bank select change only by sfr write
    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            user_flag_a_q <= 1'b0;
            user_flag_b_q <= 1'b0;
            bank_select_q <= CCSF_RST_BANK;
        end else if (wr_psw) begin
            user_flag_a_q <= SFR_WDATA[CCSF_PSW_USER_FLAG_A];
            user_flag_b_q <= SFR_WDATA[CCSF_PSW_USER_FLAG_B];
            bank_select_q <= {SFR_WDATA[CCSF_PSW_BANK_HI],
                              SFR_WDATA[CCSF_PSW_BANK_LO]};
        end
    end

    // parity tracks the accumulator's next value, so it never lags a
    // write; software writes to this bit have no lasting effect
    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            parity_q <= 1'b0;
        end else begin
            parity_q <= ^acc_d;
        end
    end

    // auxiliary control, upper nibble unimplemented
    assign aux_d = wr_aux ? SFR_WDATA[CCSF_AUX_WIDTH-1:0] : aux_q;

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aux_q <= CCSF_RST_AUX;
        end else begin
            aux_q <= aux_d;
        end
    end

    // registered copy of the pointer that the next select will show
    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            data_pointer_out_q <= CCSF_RST_DATA_POINTER;
        end else begin
            data_pointer_out_q <= ptr_d[aux_d[CCSF_AUX_POINTER_SELECT]];
        end
    end

    // status word as software sees it
    logic [7:0] psw_now;

    assign psw_now = {cy_q, ac_q, user_flag_a_q, bank_select_q,
                      ov_q, user_flag_b_q, parity_q};

    // read path: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= CCSF_RST_BYTE;
            hit_q   <= 1'b0;
        end else if (SFR_RD) begin
            hit_q <= 1'b1;
            unique case (SFR_ADDR)
                CCSF_ADDR_STACK_POINTER:       rdata_q <= sp_q;
                CCSF_ADDR_DATA_POINTER_LOW:
                    rdata_q <= ptr_q[aux_q[CCSF_AUX_POINTER_SELECT]][7:0];
                CCSF_ADDR_DATA_POINTER_HIGH:
                    rdata_q <= ptr_q[aux_q[CCSF_AUX_POINTER_SELECT]][15:8];
                CCSF_ADDR_PROGRAM_STATUS_WORD: rdata_q <= psw_now;
                CCSF_ADDR_ACCUMULATOR:         rdata_q <= acc_q;
                CCSF_ADDR_SECOND_OPERAND:      rdata_q <= b_q;
                CCSF_ADDR_AUXILIARY_CONTROL:   rdata_q <= {4'h0, aux_q};
                default: begin
                    rdata_q <= CCSF_RST_BYTE;
                    hit_q   <= 1'b0;
                end
            endcase
        end else begin
            rdata_q <= CCSF_RST_BYTE;
            hit_q   <= 1'b0;
        end
    end

    // outputs, all wired from flops
    assign SFR_RDATA     = rdata_q;
    assign SFR_HIT       = hit_q;
    assign ACC_VALUE     = acc_q;
    assign B_VALUE       = b_q;
    assign STACK_POINTER = sp_q;
    assign DATA_POINTER  = data_pointer_out_q;
    assign PSW_VALUE     = psw_now;
    assign REG_BANK_BASE = {3'b000, bank_select_q, 3'b000};
    assign AUX_CTRL      = aux_q[CCSF_AUX_WIDTH-1:1];

endmodule : ccsf_core_sfr
`default_nettype wire

// file: tb/ccsf_core_sfr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ccsf_core_sfr_checker
    import ccsf_pkg::*;
(
    input wire logic              CLK_SYS,        // clock
    input wire logic              ARST_N,         // async reset
    input wire logic [7:0]        SFR_ADDR,       // address
    input wire logic              SFR_WR,         // write strobe
    input wire logic [7:0]        SFR_WDATA,      // write data
    input wire logic              SFR_RD,         // read strobe
    input wire ccsf_alu_req_type  ALU_REQ,        // alu request
    input wire ccsf_stack_op_type STACK_OP,       // stack op
    input wire ccsf_dp_op_type    DP_OP,          // pointer op
    input wire logic [15:0]       DP_LOAD_VALUE,  // pointer load value
    input wire logic [7:0]        SFR_RDATA,      // read data
    input wire logic              SFR_HIT,        // read hit
    input wire logic [7:0]        ACC_VALUE,      // accumulator
    input wire logic [7:0]        B_VALUE,        // second operand
    input wire logic [7:0]        STACK_POINTER,  // stack top
    input wire logic [15:0]       DATA_POINTER,   // active pointer
    input wire logic [7:0]        PSW_VALUE,      // status word
    input wire logic [7:0]        REG_BANK_BASE   // bank base
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // answer for one cycle, then zero unless another read was taken
    sequence rd_ans(v);
        SFR_HIT && SFR_RDATA == v ##1 ($past(SFR_RD) || SFR_RDATA == 8'h00);
    endsequence
    // stack steps wrap modulo 256, so steps are written as byte adds
    property stk_p(ccsf_stack_op_type op, logic [7:0] st);
        STACK_OP == op |=> STACK_POINTER == $past(STACK_POINTER) + st;
    endproperty
    parity_track_a: assert property (PSW_VALUE[0] == ^ACC_VALUE)
        else $error("parity off");
    bank_base_a: assert property (REG_BANK_BASE == {3'b000, PSW_VALUE[4:3], 3'b000})
        else $error("bank base off");
    push_step_a: assert property (stk_p(STK_PUSH, 8'h01)) else $error("push step");
    pop_step_a: assert property (stk_p(STK_POP, 8'hFF)) else $error("pop step");
    call_step_a: assert property (stk_p(STK_CALL, 8'h02)) else $error("call step");
    ret_step_a: assert property (stk_p(STK_RET, 8'hFE)) else $error("ret step");
    acc_read_a: assert property (SFR_RD && SFR_ADDR == CCSF_ADDR_ACCUMULATOR
        |=> rd_ans($past(ACC_VALUE))) else $error("acc read");
    hole_read_a: assert property (SFR_RD && SFR_ADDR == 8'h90 |=> !SFR_HIT && SFR_RDATA == 8'h00)
        else $error("unmapped read");
    add_sum_a: assert property (ALU_REQ.op == ALU_ADD
        |=> {PSW_VALUE[7], ACC_VALUE} == $past(ACC_VALUE) + $past(ALU_REQ.operand))
        else $error("add result");
    mul_result_a: assert property (ALU_REQ.op == ALU_MUL
        |=> {B_VALUE, ACC_VALUE} == $past(ACC_VALUE) * $past(B_VALUE) && !PSW_VALUE[7]
        && PSW_VALUE[2] == (B_VALUE != 8'h00) && PSW_VALUE[6] == $past(PSW_VALUE[6]))
        else $error("mul result");
    psw_write_a: assert property (SFR_WR && SFR_ADDR == CCSF_ADDR_PROGRAM_STATUS_WORD
        && ALU_REQ.op == ALU_NONE |=> PSW_VALUE[7:1] == $past(SFR_WDATA[7:1]))
        else $error("status write");
    dp_load_a: assert property (DP_OP == DP_LOAD
        && !(SFR_WR && SFR_ADDR == CCSF_ADDR_AUXILIARY_CONTROL)
        |=> DATA_POINTER == $past(DP_LOAD_VALUE)) else $error("pointer load");
    set_carry_a: assert property (ALU_REQ.op == ALU_SETC |=> PSW_VALUE[7])
        else $error("setc");
endmodule : ccsf_core_sfr_checker
bind ccsf_core_sfr ccsf_core_sfr_checker u_ccsf_core_sfr_checker (.*);
`default_nettype wire

// file: tb/tb_ccsf_core_sfr.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ccsf_core_sfr
    import ccsf_pkg::*;
;
    logic              CLK_SYS = 1'b0, ARST_N = 1'b0, SFR_WR = 1'b0, SFR_RD = 1'b0, SFR_HIT;
    logic [7:0]        SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, ACC_VALUE, B_VALUE;
    logic [7:0]        STACK_POINTER, PSW_VALUE, REG_BANK_BASE;
    logic [15:0]       DP_LOAD_VALUE = 16'h0000, DATA_POINTER;
    logic [2:0]        AUX_CTRL;
    ccsf_alu_req_type  ALU_REQ = '0;
    ccsf_byte_wr_type  ACC_WR = '0;
    ccsf_stack_op_type STACK_OP = STK_NONE;
    ccsf_dp_op_type    DP_OP = DP_NONE;
    int                errors = 0, checks = 0, cycles = 0;
    logic [7:0]        ra [7] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0, 8'hF8};
    logic [7:0]        rv [7] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // acc, operand, result, carry in, {cy, ac, ov}
    logic [31:0]       tv [5] = '{32'h8080_0005, 32'h010F_1002, 32'h00FF_0016,
                                  32'h1001_0F02, 32'h8001_7E13};
    ccsf_alu_op_type   ops [5] = '{ALU_ADD, ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_SUBB};

    ccsf_core_sfr u_ccsf_core_sfr (.*);

    // free running 20 mhz clock
    initial begin
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    // hang guard; the run needs about 110 cycles
    always @(posedge CLK_SYS) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // strobes last one cycle; results are sampled 1 ns after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        {SFR_WR, SFR_ADDR, SFR_WDATA} <= {1'b1, a, d};
        @(posedge CLK_SYS);
        SFR_WR <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(posedge CLK_SYS);
        {SFR_RD, SFR_ADDR} <= {1'b1, a};
        @(posedge CLK_SYS);
        SFR_RD <= 1'b0;
        #1;
        chk(SFR_RDATA, exp);
        chk(SFR_HIT, hit);
    endtask : rd
    task automatic core(input ccsf_alu_req_type r, input ccsf_byte_wr_type w,
                        input ccsf_stack_op_type s, input ccsf_dp_op_type d,
                        input logic [15:0] v);
        @(posedge CLK_SYS);
        ALU_REQ <= r;
        ACC_WR <= w;
        STACK_OP <= s;
        DP_OP <= d;
        DP_LOAD_VALUE <= v;
        @(posedge CLK_SYS);
        ALU_REQ <= '0;
        ACC_WR <= '0;
        STACK_OP <= STK_NONE;
        DP_OP <= DP_NONE;
        #1;
    endtask : core
    task automatic alu(input ccsf_alu_op_type o, input logic [7:0] x, input logic c,
                       input logic [8:0] w);
        core('{o, x, c}, w, STK_NONE, DP_NONE, 16'h0000);
    endtask : alu
    task automatic stk(input ccsf_stack_op_type s, input logic [7:0] e);
        core('0, '0, s, DP_NONE, 16'h0000);
        chk(STACK_POINTER, e);
    endtask : stk
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // main sequence: reset, then one group of calls per behaviour
    initial begin
        repeat (5) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        foreach (ra[i]) rd(ra[i], rv[i], 1'b1);
        rd(8'h90, 8'h00, 1'b0);
        wr(8'hE0, 8'h03);
        chk(PSW_VALUE, 8'h00);
        wr(8'hE0, 8'h07);
        chk({ACC_VALUE, PSW_VALUE}, 16'h0701);
        for (int i = 0; i < 4; i++) begin
            wr(8'hD0, 8'(i * 8));
            chk(REG_BANK_BASE, 8'(i * 8));
        end
        // parity bit write is dropped, hardware keeps it
        wr(8'hD0, 8'hE6);
        rd(8'hD0, 8'hE7, 1'b1);
        foreach (tv[i]) begin
            alu(ALU_CARRY_LOAD, 8'h00, tv[i][4], {1'b1, tv[i][31:24]});
            alu(ops[i], tv[i][23:16], 1'b0, 9'h000);
            chk({ACC_VALUE, PSW_VALUE[7:6], PSW_VALUE[2]}, {tv[i][15:8], tv[i][2:0]});
        end
        alu(ALU_SETC, 8'h00, 1'b0, 9'h110);
        chk(PSW_VALUE[7], 1'b1);
        wr(8'hF0, 8'h20);
        alu(ALU_MUL, 8'h00, 1'b0, 9'h000);
        chk({B_VALUE, ACC_VALUE, PSW_VALUE[7:6], PSW_VALUE[2]}, {16'h0200, 3'b011});
        alu(ALU_SETC, 8'h00, 1'b0, 9'h125);
        wr(8'hF0, 8'h07);
        alu(ALU_DIV, 8'h00, 1'b0, 9'h000);
        chk({B_VALUE, ACC_VALUE, PSW_VALUE[7:6], PSW_VALUE[2]}, {16'h0205, 3'b010});
        wr(8'hF0, 8'h00);
        alu(ALU_DIV, 8'h00, 1'b0, 9'h000);
        chk({B_VALUE, ACC_VALUE, PSW_VALUE[7:6], PSW_VALUE[2]}, {16'h0005, 3'b011});
        chk({PSW_VALUE[5], PSW_VALUE[1]}, 2'b11);
        alu(ALU_SETC, 8'h00, 1'b0, 9'h000);
        alu(ALU_CLRC, 8'h00, 1'b0, 9'h000);
        chk(PSW_VALUE[7], 1'b0);
        stk(STK_PUSH, 8'h08);
        stk(STK_CALL, 8'h0A);
        stk(STK_RET, 8'h08);
        stk(STK_POP, 8'h07);
        wr(8'h81, 8'hFF);
        stk(STK_PUSH, 8'h00);
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        chk(DATA_POINTER, 16'h1234);
        wr(8'hF8, 8'h01);
        chk(DATA_POINTER, 16'h0000);
        core('0, '0, STK_NONE, DP_LOAD, 16'hBEEF);
        core('0, '0, STK_NONE, DP_INC, 16'h0000);
        rd(8'h83, 8'hBE, 1'b1);
        wr(8'hF8, 8'hFE);
        chk({AUX_CTRL, DATA_POINTER}, {3'b111, 16'h1234});
        rd(8'hF8, 8'h0E, 1'b1);
        report_and_stop();
    end
endmodule : tb_ccsf_core_sfr
`default_nettype wire
